// >>> hdl/pmsp_defs.svh
// Constants for the physical layer management service port.
`ifndef PMSP_DEFS_SVH
`define PMSP_DEFS_SVH
`define PMSP_CLS_W 2
`define PMSP_CLS_TX_INHIBIT 2'h1
`define PMSP_CLS_RX_SOURCE 2'h2
`define PMSP_MODE_W 8
`define PMSP_SRC_LSB 0
`define PMSP_SRC_W 2
`define PMSP_LPT_LSB 4
`define PMSP_SRC_PRIMARY 2'h0
`define PMSP_SRC_ALTERNATE 2'h1
`define PMSP_SRC_LOOPED 2'h2
`define PMSP_FIELD_W 2
`define PMSP_TOPO_TOKEN_BUS 2'h1
`define PMSP_ROLE_ORIG_ONLY 2'h1
`define PMSP_STATUS_OK 1'b1
`define PMSP_STATUS_FAIL 1'b0
`define PMSP_TX_INH_RST 1'b0
`endif

// >>> hdl/pmsp_pkg.sv
// Types shared by the management service port modules.
`include "pmsp_defs.svh"
package pmsp_pkg;
    typedef enum logic [1:0] {
        PMSP_SRC_PRI = 2'b00,
        PMSP_SRC_ALT = 2'b01,
        PMSP_SRC_LOOP = 2'b10
    } pmsp_rxsrc_t;
endpackage

// >>> hdl/pmsp_mode_if.sv
// Carrier between the request logic and the mode register.
`timescale 1ns/100ps
interface pmsp_mode_if #(
    parameter int N = 1,
    parameter int LW = 1
);
    logic soft_rst;
    logic tx_wr;
    logic [N-1:0] tx_val;
    logic rx_wr;
    pmsp_pkg::pmsp_rxsrc_t rx_src_val;
    logic [LW-1:0] lpt_val;
    logic [N-1:0] jabber;
    logic [N-1:0] tx_inhibit;
    pmsp_pkg::pmsp_rxsrc_t rx_src;
    logic [LW-1:0] lpt;
    modport ctl(
        output soft_rst, tx_wr, tx_val, rx_wr, rx_src_val, lpt_val, jabber,
        input tx_inhibit, rx_src, lpt
    );
    modport mode(
        input soft_rst, tx_wr, tx_val, rx_wr, rx_src_val, lpt_val, jabber,
        output tx_inhibit, rx_src, lpt
    );
endinterface

// >>> hdl/pmsp_mode_reg.sv
// Operating mode register with jabber hold and loopback inhibit.
`timescale 1ns/100ps
`include "pmsp_defs.svh"
module pmsp_mode_reg #(
    parameter int N = 1,
    parameter int LW = 1
)(
    input wire logic mclk,
    input wire logic rst_n,
    pmsp_mode_if.mode m
);
    logic [N-1:0] cmd_inh;
    logic [N-1:0] next_cmd_inh;
    logic [N-1:0] jab;
    logic [N-1:0] next_jab;
    pmsp_pkg::pmsp_rxsrc_t src;
    pmsp_pkg::pmsp_rxsrc_t next_src;
    logic [LW-1:0] lpt;
    logic [LW-1:0] next_lpt;

    always_comb
    begin
        next_cmd_inh = cmd_inh;
        next_jab = jab | m.jabber; // (RL12)
        next_src = src;
        next_lpt = lpt;
        if (m.soft_rst)
        begin
            next_cmd_inh = {N{`PMSP_TX_INH_RST}}; // (RL1)
            next_jab = '0;
            next_src = pmsp_pkg::PMSP_SRC_PRI;
            next_lpt = '0;
        end
        else
        begin
            if (m.tx_wr)
            begin
                next_cmd_inh = m.tx_val; // (RL6)
                // A trip in the same cycle as an enable still holds the line.
                next_jab = (jab & m.tx_val) | m.jabber;
            end
            if (m.rx_wr)
            begin
                next_src = m.rx_src_val; // (RL7)
                next_lpt = m.lpt_val; // (RL8)
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_inh <= {N{`PMSP_TX_INH_RST}};
            jab <= '0;
            src <= pmsp_pkg::PMSP_SRC_PRI;
            lpt <= '0;
        end
        else
        begin
            cmd_inh <= next_cmd_inh;
            jab <= next_jab;
            src <= next_src;
            lpt <= next_lpt;
        end
    end

    assign m.tx_inhibit = cmd_inh | jab |
        {N{src == pmsp_pkg::PMSP_SRC_LOOP}}; // (RL9)
    assign m.rx_src = src;
    assign m.lpt = lpt;
endmodule

// >>> hdl/pmsp_port.sv
// Management service port of the physical layer: reset, mode select, notice.
`timescale 1ns/100ps
`include "pmsp_defs.svh"
// How it works
// (RL1) A reset request returns every mode to its power-up value.
// (RL2) Each reset request gets a confirm one cycle later with a status.
// (RL3) Reset confirm reports token bus topology and originate-only role.
// (RL4) Management picks the access protocol from topology and role.
// (RL5) Only transmitter-inhibit and receive-source classes pass; others fail.
// (RL6) Inhibit request bits set each transmitter off or on individually.
// (RL7) Primary, alternate or looped selects which receiver is on.
// (RL8) A looped request selects the designated internal loopback point.
// (RL9) While looped back all transmitters are inhibited.
// (RL10) Every mode request is confirmed next cycle, echoing class and status; the port drops one arriving with a reset request.
// (RL11) A notice pulses when modes drift from the last confirm or notice.
// (RL12) A jabber shutdown is an uncommanded change and raises the notice; the port raises none for a trip in the cycle of a mode request.
// (RL13) Management keeps one request outstanding and waits for its confirm.
module pmsp_port #(
    parameter int N = 1,
    parameter int NLOOP = 1,
    parameter int LW = 1
)(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic layer_reset_req,
    output logic layer_reset_cnf,
    output logic reset_status,
    output logic [`PMSP_FIELD_W-1:0] network_topology_field,
    output logic [`PMSP_FIELD_W-1:0] station_role_field,
    input wire logic mode_select_req,
    input wire logic [`PMSP_CLS_W-1:0] mode_class,
    input wire logic [`PMSP_MODE_W-1:0] new_mode,
    output logic mode_select_cnf,
    output logic [`PMSP_CLS_W-1:0] cnf_mode_class,
    output logic cnf_status,
    output logic uncommanded_mode_notice,
    input wire logic [N-1:0] jabber_trip,
    output logic [N-1:0] tx_inhibit,
    output logic rx_primary_on,
    output logic rx_alternate_on,
    output logic loopback_active,
    output logic [LW-1:0] loop_point
);
    localparam int CW = N + `PMSP_SRC_W + LW;

    pmsp_mode_if #(.N(N), .LW(LW)) mif();

    pmsp_mode_reg #(.N(N), .LW(LW)) u_mode (
        .mclk(mclk),
        .rst_n(rst_n),
        .m(mif.mode)
    );

    logic next_rcnf;
    logic next_rstat;
    logic next_cnf;
    logic [`PMSP_CLS_W-1:0] next_cls;
    logic next_ok;
    logic next_notice;
    logic [CW-1:0] cur;
    logic [CW-1:0] snap;
    logic [CW-1:0] next_snap;
    logic ok;

    function automatic logic mode_ok(
        input logic [`PMSP_CLS_W-1:0] cls,
        input logic [`PMSP_MODE_W-1:0] nm
    );
        logic [`PMSP_SRC_W-1:0] s;
        logic [LW-1:0] p;
        s = nm[`PMSP_SRC_LSB +: `PMSP_SRC_W];
        p = nm[`PMSP_LPT_LSB +: LW];
        case (cls)
            `PMSP_CLS_TX_INHIBIT: mode_ok = 1'b1;
            `PMSP_CLS_RX_SOURCE:
                mode_ok = (s == `PMSP_SRC_PRIMARY) ||
                    (s == `PMSP_SRC_ALTERNATE) ||
                    ((s == `PMSP_SRC_LOOPED) && (int'(p) < NLOOP));
            default: mode_ok = 1'b0; // (RL5)
        endcase
    endfunction

    assign cur = {mif.tx_inhibit, mif.rx_src, mif.lpt};
    assign mif.jabber = jabber_trip;

    always_comb
    begin
        next_rcnf = 1'b0;
        next_rstat = reset_status;
        next_cnf = 1'b0;
        next_cls = cnf_mode_class;
        next_ok = cnf_status;
        next_notice = 1'b0;
        next_snap = snap;
        ok = mode_ok(mode_class, new_mode);
        mif.soft_rst = 1'b0;
        mif.tx_wr = 1'b0;
        mif.tx_val = new_mode[N-1:0];
        mif.rx_wr = 1'b0;
        mif.rx_src_val =
            pmsp_pkg::pmsp_rxsrc_t'(new_mode[`PMSP_SRC_LSB +: `PMSP_SRC_W]);
        mif.lpt_val = '0;
        if (mif.rx_src_val == pmsp_pkg::PMSP_SRC_LOOP)
        begin
            mif.lpt_val = new_mode[`PMSP_LPT_LSB +: LW]; // (RL8)
        end
        // A reset request outranks a mode request arriving with it.
        if (layer_reset_req)
        begin
            mif.soft_rst = 1'b1; // (RL1)
            next_rcnf = 1'b1; // (RL2)
            next_rstat = `PMSP_STATUS_OK;
            next_cls = '0;
            next_ok = `PMSP_STATUS_FAIL;
        end
        else if (mode_select_req)
        begin
            next_cnf = 1'b1; // (RL10)
            next_cls = mode_class;
            next_ok = ok ? `PMSP_STATUS_OK : `PMSP_STATUS_FAIL; // (RL5)
            mif.tx_wr = ok && (mode_class == `PMSP_CLS_TX_INHIBIT); // (RL6)
            mif.rx_wr = ok && (mode_class == `PMSP_CLS_RX_SOURCE); // (RL7)
        end
        // A confirm resynchronises the reference; a drift seen in that
        // same cycle is folded into it rather than reported twice.
        if (mode_select_cnf || layer_reset_cnf)
        begin
            next_snap = cur;
        end
        else if (cur != snap)
        begin
            next_notice = 1'b1; // (RL11)
            next_snap = cur;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            layer_reset_cnf <= 1'b0;
            reset_status <= `PMSP_STATUS_OK;
            mode_select_cnf <= 1'b0;
            cnf_mode_class <= '0;
            cnf_status <= `PMSP_STATUS_FAIL;
            uncommanded_mode_notice <= 1'b0;
            snap <= {{N{`PMSP_TX_INH_RST}}, `PMSP_SRC_PRIMARY, {LW{1'b0}}};
            network_topology_field <= `PMSP_TOPO_TOKEN_BUS;
            station_role_field <= `PMSP_ROLE_ORIG_ONLY;
        end
        else
        begin
            layer_reset_cnf <= next_rcnf;
            reset_status <= next_rstat;
            mode_select_cnf <= next_cnf;
            cnf_mode_class <= next_cls;
            cnf_status <= next_ok;
            uncommanded_mode_notice <= next_notice;
            snap <= next_snap;
            network_topology_field <= `PMSP_TOPO_TOKEN_BUS; // (RL3)
            station_role_field <= `PMSP_ROLE_ORIG_ONLY; // (RL3)
        end
    end

    assign tx_inhibit = mif.tx_inhibit;
    assign rx_primary_on = (mif.rx_src == pmsp_pkg::PMSP_SRC_PRI);
    assign rx_alternate_on = (mif.rx_src == pmsp_pkg::PMSP_SRC_ALT);
    assign loopback_active = (mif.rx_src == pmsp_pkg::PMSP_SRC_LOOP);
    assign loop_point = mif.lpt;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_reset_cnf_next: assert property ( // (RL2)
        layer_reset_req |=> layer_reset_cnf && reset_status)
        else $error("reset request not confirmed next cycle");
    a_reset_fields: assert property ( // (RL3)
        layer_reset_cnf |-> network_topology_field == `PMSP_TOPO_TOKEN_BUS
            && station_role_field == `PMSP_ROLE_ORIG_ONLY)
        else $error("reset confirm fields wrong");
    a_reset_poweron: assert property ( // (RL1)
        layer_reset_req && jabber_trip == '0 |=> rx_primary_on
            && !loopback_active && tx_inhibit == {N{`PMSP_TX_INH_RST}})
        else $error("reset request did not restore power-up modes");
    a_select_echo: assert property ( // (RL10)
        mode_select_req && !layer_reset_req |=> mode_select_cnf
            && cnf_mode_class == $past(mode_class))
        else $error("mode select not confirmed with its class");
    // A jabber trip may legally move the modes beside a refused request.
    a_bad_class_fail: assert property ( // (RL5)
        mode_select_req && !layer_reset_req && jabber_trip == '0
            && mode_class != `PMSP_CLS_TX_INHIBIT
            && mode_class != `PMSP_CLS_RX_SOURCE
        |=> !cnf_status && $stable(cur))
        else $error("unsupported class not failed");
    a_bad_mode_fail: assert property ( // (RL5)
        mode_select_req && !layer_reset_req && !ok && jabber_trip == '0
        |=> !cnf_status && $stable(cur))
        else $error("refused mode changed the operating modes");
    a_tx_apply: assert property ( // (RL6)
        mode_select_req && !layer_reset_req
            && mode_class == `PMSP_CLS_TX_INHIBIT
        |=> cnf_status && ($past(new_mode[N-1:0]) & ~tx_inhibit) == '0)
        else $error("transmitter inhibit request not applied");
    a_loop_inhibit: assert property ( // (RL9)
        loopback_active |-> tx_inhibit == {N{1'b1}})
        else $error("transmitter active during loopback");
    a_rx_source: assert property ( // (RL7)
        mode_select_req && !layer_reset_req && ok
            && mode_class == `PMSP_CLS_RX_SOURCE
        |=> !(rx_primary_on && rx_alternate_on)
            && (loopback_active == !(rx_primary_on || rx_alternate_on)))
        else $error("receiver selection inconsistent");
    a_loop_point: assert property ( // (RL8)
        mode_select_req && !layer_reset_req && ok
            && mode_class == `PMSP_CLS_RX_SOURCE
            && new_mode[`PMSP_SRC_LSB +: `PMSP_SRC_W] == `PMSP_SRC_LOOPED
        |=> loopback_active
            && loop_point == $past(new_mode[`PMSP_LPT_LSB +: LW]))
        else $error("loopback point not selected");
    a_jabber_notice: assert property ( // (RL12)
        jabber_trip[0] && !tx_inhibit[0] && !layer_reset_req
            && !mode_select_req && !mode_select_cnf && !layer_reset_cnf
        |=> tx_inhibit[0] ##1 uncommanded_mode_notice)
        else $error("jabber shutdown not notified");
    a_notice_cause: assert property ( // (RL11)
        uncommanded_mode_notice |-> $past(cur != snap)
            && !$past(mode_select_cnf) && !$past(layer_reset_cnf))
        else $error("notice without uncommanded change");

    c_reset: cover property (layer_reset_req ##1 layer_reset_cnf);
    c_loop: cover property (mode_select_cnf && cnf_status && loopback_active);
    c_fail: cover property (mode_select_cnf && !cnf_status);
    c_jabber: cover property (jabber_trip != '0 ##2 uncommanded_mode_notice);
endmodule

// >>> dv/pmsp_mgmt_model.sv
// Station management model that issues reset and mode requests.
`timescale 1ns/100ps
`include "pmsp_defs.svh"
module pmsp_mgmt_model (
    input wire logic mclk,
    output logic layer_reset_req,
    output logic mode_select_req,
    output logic [`PMSP_CLS_W-1:0] mode_class,
    output logic [`PMSP_MODE_W-1:0] new_mode,
    input wire logic layer_reset_cnf,
    input wire logic mode_select_cnf
);
    initial
    begin
        layer_reset_req = 1'b0;
        mode_select_req = 1'b0;
        mode_class = 2'h0;
        new_mode = 8'h00;
    end

    // Only one request is open at a time; it returns on the confirm.
    // Waits at most five cycles, so a lost confirm shows as a latency of 5.
    task automatic issue(input logic rst, input logic [1:0] cls,
                         input logic [7:0] nm, output int lat);
        logic got;
        got = 1'b0;
        lat = 0;
        @(negedge mclk);
        layer_reset_req = rst;
        mode_select_req = ~rst;
        mode_class = cls;
        new_mode = nm;
        @(negedge mclk);
        layer_reset_req = 1'b0;
        mode_select_req = 1'b0;
        // Released fields carry the inverse so stale values are never used.
        mode_class = ~cls;
        new_mode = ~nm;
        while (!got && lat < 5)
        begin
            lat++;
            got = rst ? layer_reset_cnf : mode_select_cnf;
            if (!got)
                @(negedge mclk);
        end
    endtask
endmodule

// >>> dv/pmsp_port_tb.sv
// Self-checking testbench of the management service port.
`timescale 1ns/100ps
`include "pmsp_defs.svh"
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module pmsp_port_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] jabber_trip = 2'b00;
    logic layer_reset_req, layer_reset_cnf, reset_status;
    logic [1:0] network_topology_field, station_role_field;
    logic mode_select_req, mode_select_cnf, cnf_status;
    logic [1:0] mode_class, cnf_mode_class, tx_inhibit;
    logic [7:0] new_mode;
    logic uncommanded_mode_notice, rx_primary_on, rx_alternate_on;
    logic loopback_active;
    logic [1:0] loop_point;
    int n_errors = 0;
    int n_tests = 0;

    pmsp_port #(.N(2), .NLOOP(2), .LW(2)) DUT (
        .mclk(mclk), .rst_n(rst_n), .layer_reset_req(layer_reset_req),
        .layer_reset_cnf(layer_reset_cnf), .reset_status(reset_status),
        .network_topology_field(network_topology_field),
        .station_role_field(station_role_field),
        .mode_select_req(mode_select_req), .mode_class(mode_class),
        .new_mode(new_mode), .mode_select_cnf(mode_select_cnf),
        .cnf_mode_class(cnf_mode_class), .cnf_status(cnf_status),
        .uncommanded_mode_notice(uncommanded_mode_notice),
        .jabber_trip(jabber_trip), .tx_inhibit(tx_inhibit),
        .rx_primary_on(rx_primary_on), .rx_alternate_on(rx_alternate_on),
        .loopback_active(loopback_active), .loop_point(loop_point)
    );

    pmsp_mgmt_model MGMT (
        .mclk(mclk), .layer_reset_req(layer_reset_req),
        .mode_select_req(mode_select_req), .mode_class(mode_class),
        .new_mode(new_mode), .layer_reset_cnf(layer_reset_cnf),
        .mode_select_cnf(mode_select_cnf)
    );

    initial
    begin
        forever #25 mclk = ~mclk;
    end

    task automatic tally_and_finish;
        $display("tests=%0d mismatches=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic t_tx;
        int lat;
        logic [1:0] v[3] = '{2'b10, 2'b01, 2'b00};
        for (int i = 0; i < 3; i++)
        begin
            MGMT.issue(1'b0, `PMSP_CLS_TX_INHIBIT, {6'h00, v[i]}, lat);
            `CHK(lat, 1)
            `CHK(cnf_mode_class, `PMSP_CLS_TX_INHIBIT)
            `CHK(cnf_status, `PMSP_STATUS_OK)
            `CHK(tx_inhibit, v[i])
        end
        $display("test tx inhibit done");
    endtask

    task automatic t_rx;
        int lat;
        logic [7:0] nm[3] = '{8'h01, 8'h12, 8'h00};
        logic [4:0] ex[3] = '{5'b01000, 5'b00101, 5'b10000};
        for (int i = 0; i < 3; i++)
        begin
            MGMT.issue(1'b0, `PMSP_CLS_RX_SOURCE, nm[i], lat);
            `CHK(lat, 1)
            `CHK(cnf_status, `PMSP_STATUS_OK)
            `CHK({rx_primary_on, rx_alternate_on}, ex[i][4:3])
            `CHK({loopback_active, loop_point}, ex[i][2:0])
            `CHK(tx_inhibit, {2{ex[i][2]}})
        end
        $display("test rx source done");
    endtask

    task automatic t_bad;
        int lat;
        logic [1:0] c[4] = '{2'h0, 2'h3, `PMSP_CLS_RX_SOURCE,
            `PMSP_CLS_RX_SOURCE};
        // The last case asks for a loop point beyond the last one built.
        logic [7:0] nm[4] = '{8'h03, 8'h03, 8'h03, 8'h22};
        for (int i = 0; i < 4; i++)
        begin
            MGMT.issue(1'b0, c[i], nm[i], lat);
            `CHK(lat, 1)
            `CHK(cnf_mode_class, c[i])
            `CHK(cnf_status, `PMSP_STATUS_FAIL)
            `CHK({rx_primary_on, loopback_active, tx_inhibit}, 4'h8)
        end
        $display("test refused class done");
    endtask

    task automatic t_jab;
        int seen;
        seen = 0;
        @(negedge mclk);
        jabber_trip = 2'b01;
        @(negedge mclk);
        jabber_trip = 2'b00;
        repeat (4)
        begin
            @(negedge mclk);
            seen += int'(uncommanded_mode_notice === 1'b1);
        end
        `CHK(seen, 1)
        `CHK(tx_inhibit, 2'b01)
        $display("test jabber notice done");
    endtask

    task automatic t_reset;
        int lat;
        MGMT.issue(1'b0, `PMSP_CLS_RX_SOURCE, 8'h12, lat);
        MGMT.issue(1'b1, 2'h2, 8'h00, lat);
        `CHK(lat, 1)
        `CHK(reset_status, `PMSP_STATUS_OK)
        `CHK(network_topology_field, `PMSP_TOPO_TOKEN_BUS)
        `CHK(station_role_field, `PMSP_ROLE_ORIG_ONLY)
        `CHK({network_topology_field, station_role_field}, 4'h5)
        `CHK({rx_primary_on, loopback_active, loop_point}, 4'b1000)
        `CHK({tx_inhibit, cnf_status}, 3'b000)
        $display("test layer reset done");
    endtask

    initial
    begin
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        t_tx();
        t_rx();
        t_bad();
        t_jab();
        t_reset();
        tally_and_finish();
    end

    // The tests need well under 200 cycles; a hang is cut off at 1000.
    initial
    begin
        repeat (1000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
endmodule
